/* File: design/ctp_pkg.sv */
// Purpose: shared constants and types for the cascadable timer pair
// Assumes: 32-bit classic Wishbone, word-aligned registers
// Notes: offsets are byte addresses
package ctp_pkg;
  localparam int CTP_CNT_W = 16;
  localparam logic [7:0] CTP_OFS_CTRL = 8'h00;
  localparam logic [7:0] CTP_OFS_MODE0 = 8'h04;
  localparam logic [7:0] CTP_OFS_MODE1 = 8'h08;
  localparam logic [7:0] CTP_OFS_RELOAD0 = 8'h0C;
  localparam logic [7:0] CTP_OFS_RELOAD1 = 8'h10;
  localparam logic [7:0] CTP_OFS_COUNT0 = 8'h14;
  localparam logic [7:0] CTP_OFS_COUNT1 = 8'h18;
  localparam logic [7:0] CTP_OFS_STATUS = 8'h1C;
  localparam logic [7:0] CTP_OFS_MASK = 8'h20;
  // mode register fields and reset values
  localparam int CTP_MODE_SEL_LSB = 0;
  localparam int CTP_MODE_PULSE_BIT = 2;
  localparam logic [15:0] CTP_RELOAD_RST = 16'hFFFF;
  localparam logic [15:0] CTP_COUNT_RST = 16'hFFFF;
  localparam logic [1:0] CTP_MASK_RST = 2'h0;

  typedef enum logic [1:0] {
    CTP_MODE_TIMER = 2'b00,
    CTP_MODE_EVENT = 2'b01,
    CTP_MODE_ONESHOT = 2'b10
  } ctp_mode_e;

  typedef struct packed {
    ctp_mode_e mode;
    logic pulse_en;
    logic start;
    logic [15:0] reload;
  } ctp_cfg_s;

  typedef struct packed {
    logic [15:0] count;
    logic running;
    logic underflow;
    logic pin;
  } ctp_stat_s;
endpackage

/* File: design/ctp_timer_unit.sv */
// Purpose: one reloadable down-counter with timer, event and one-shot modes
// Assumes: trig_i is a single-cycle pulse on clk_i; tick_i may be held high every clock
// Notes: underflow is the wrap past zero; one-shot ends on reaching zero
module ctp_timer_unit
  import ctp_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire ctp_pkg::ctp_cfg_s cfg_i,
  input wire logic tick_i,
  input wire logic trig_i,
  output ctp_pkg::ctp_stat_s stat_o
);
  // the counter datapath is fixed at sixteen bits
  if (CNT_W != 16)
  begin : g_width_check
    $error("ctp_timer_unit supports only a 16-bit counter");
  end

  logic [15:0] count;
  logic armed;
  logic pin;
  logic event_tick;
  logic uf;
  logic os_done;
  logic is_os;

  assign is_os = (cfg_i.mode == CTP_MODE_ONESHOT);
  assign event_tick = cfg_i.start && tick_i && (!is_os || armed);
  assign uf = event_tick && !is_os && (count == 16'h0000);
  assign os_done = event_tick && is_os && (count == 16'h0001);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cfg_i.start || !is_os)
      armed <= 1'b0;
    else if (trig_i && !armed)
      armed <= 1'b1;
    else if (os_done)
      armed <= 1'b0;
  end

  // idle until start; decrement per tick; reload
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count <= CTP_COUNT_RST;
    else if (uf || os_done)
      count <= cfg_i.reload;
    else if (is_os && !armed)
      count <= cfg_i.reload;
    else if (event_tick)
      count <= count - 16'h0001;
  end

  // high at start; low at end; toggle; idle low
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !cfg_i.start)
      pin <= 1'b0;
    else if (is_os)
      pin <= (trig_i && !armed) ? 1'b1 : (os_done ? 1'b0 : pin);
    else if (uf)
      pin <= ~pin;
  end

  assign stat_o.count = count;
  assign stat_o.running = cfg_i.start && (!is_os || armed);
  assign stat_o.underflow = uf || os_done;
  assign stat_o.pin = pin;
endmodule

/* File: design/ctp_top.sv */
// Purpose: pair of cascadable timers behind a classic Wishbone slave
// Assumes: 20 MHz clk_i is the undivided count source; synchronous reset
// Notes: timer 0 drives the shared port pin, timer 1 the one-shot pin
//
// Added by the designer: the placing of the registers and register access over Wishbone.
module ctp_top
  import ctp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic irq_o,
  output logic timer_pulse_pin_o,
  output logic timer_pulse_pin_oe_o,
  output logic oneshot_pulse_pin_o,
  output logic oneshot_pulse_pin_oe_o
);
  logic [1:0] start;
  logic [1:0] mode0;
  logic [1:0] mode1;
  logic pulse0;
  logic pulse1;
  logic [15:0] reload0;
  logic [15:0] reload1;
  logic [1:0] status;
  logic [1:0] mask;
  logic req;
  logic wr;
  logic rd;
  logic status_rd;
  ctp_cfg_s cfg0;
  ctp_cfg_s cfg1;
  ctp_stat_s st0;
  ctp_stat_s st1;
  logic t1_tick;
  logic [31:0] next_dat;

  assign req = cyc_i && stb_i && !ack_o;
  assign wr = req && we_i;
  assign rd = req && !we_i;
  assign status_rd = rd && (adr_i == CTP_OFS_STATUS);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= req;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start <= 2'b00;
    else if (wr && sel_i[0] && adr_i == CTP_OFS_CTRL)
      start <= dat_i[1:0];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode0 <= CTP_MODE_TIMER;
      pulse0 <= 1'b0;
    end
    else if (wr && sel_i[0] && adr_i == CTP_OFS_MODE0)
    begin
      mode0 <= dat_i[CTP_MODE_SEL_LSB +: 2];
      pulse0 <= dat_i[CTP_MODE_PULSE_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode1 <= CTP_MODE_TIMER;
      pulse1 <= 1'b0;
    end
    else if (wr && sel_i[0] && adr_i == CTP_OFS_MODE1)
    begin
      mode1 <= dat_i[CTP_MODE_SEL_LSB +: 2];
      pulse1 <= dat_i[CTP_MODE_PULSE_BIT];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reload0 <= CTP_RELOAD_RST;
    else if (wr && adr_i == CTP_OFS_RELOAD0)
    begin
      if (sel_i[0])
        reload0[7:0] <= dat_i[7:0];
      if (sel_i[1])
        reload0[15:8] <= dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      reload1 <= CTP_RELOAD_RST;
    else if (wr && adr_i == CTP_OFS_RELOAD1)
    begin
      if (sel_i[0])
        reload1[7:0] <= dat_i[7:0];
      if (sel_i[1])
        reload1[15:8] <= dat_i[15:8];
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      mask <= CTP_MASK_RST;
    else if (wr && sel_i[0] && adr_i == CTP_OFS_MASK)
      mask <= dat_i[1:0];
  end

  // timer 0 has no upstream timer, so event and one-shot fall back to timer
  always_comb
  begin
    cfg0.mode = CTP_MODE_TIMER;
    cfg0.pulse_en = pulse0;
    cfg0.start = start[0];
    cfg0.reload = reload0;
    cfg1.mode = ctp_mode_e'(mode1);
    if (mode1 == 2'b11)
      cfg1.mode = CTP_MODE_TIMER;
    cfg1.pulse_en = pulse1;
    cfg1.start = start[1];
    cfg1.reload = reload1;
  end

  // cascade: event mode ticks on timer 0 underflow
  assign t1_tick = (cfg1.mode == CTP_MODE_EVENT) ? st0.underflow : 1'b1;

  // timer 0 counts every clock of the undivided source
  ctp_timer_unit #(
    .CNT_W(CTP_CNT_W)
  ) u_timer0 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg_i(cfg0),
    .tick_i(1'b1),
    .trig_i(1'b0),
    .stat_o(st0)
  );

  // timer 0 underflow is the one-shot trigger
  ctp_timer_unit #(
    .CNT_W(CTP_CNT_W)
  ) u_timer1 (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cfg_i(cfg1),
    .tick_i(t1_tick),
    .trig_i(st0.underflow),
    .stat_o(st1)
  );

  // sticky flags; a new event beats the clearing read
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      status <= 2'b00;
    else
    begin
      status[0] <= st0.underflow | (status[0] & ~status_rd);
      status[1] <= st1.underflow | (status[1] & ~status_rd);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(status & mask);
  end

  // shared pin driven only while pulse output is selected
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      timer_pulse_pin_o <= 1'b0;
      timer_pulse_pin_oe_o <= 1'b0;
    end
    else
    begin
      timer_pulse_pin_o <= st0.pin;
      timer_pulse_pin_oe_o <= pulse0;
    end
  end

  // one-shot pin follows the unit's pulse
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      oneshot_pulse_pin_o <= 1'b0;
      oneshot_pulse_pin_oe_o <= 1'b0;
    end
    else
    begin
      oneshot_pulse_pin_o <= st1.pin;
      oneshot_pulse_pin_oe_o <= pulse1;
    end
  end

  always_comb
  begin
    next_dat = 32'h0000_0000;
    case (adr_i)
      CTP_OFS_CTRL: next_dat[1:0] = start;
      CTP_OFS_MODE0: next_dat[2:0] = {pulse0, mode0};
      CTP_OFS_MODE1: next_dat[2:0] = {pulse1, mode1};
      CTP_OFS_RELOAD0: next_dat[15:0] = reload0;
      CTP_OFS_RELOAD1: next_dat[15:0] = reload1;
      CTP_OFS_COUNT0: next_dat[15:0] = st0.count;
      CTP_OFS_COUNT1: next_dat[15:0] = st1.count;
      CTP_OFS_STATUS: next_dat[1:0] = status;
      CTP_OFS_MASK: next_dat[1:0] = mask;
      default: next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= 32'h0000_0000;
    else if (rd)
      dat_o <= next_dat;
  end
endmodule

/* File: tb/ctp_checker.sv */
// Purpose: port assertions for the timer pair
// Assumes: bench writes whole words
// Notes: shadows follow bus writes only, never design state
module ctp_checker
  import ctp_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic irq_o,
  input wire logic timer_pulse_pin_o,
  input wire logic timer_pulse_pin_oe_o,
  input wire logic oneshot_pulse_pin_o,
  input wire logic oneshot_pulse_pin_oe_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] ctrl;
  logic [1:0] mask;
  wire req = cyc_i && stb_i && !ack_o;
  wire wr = req && we_i;
  wire w_m0 = wr && adr_i == CTP_OFS_MODE0;
  wire w_m1 = wr && adr_i == CTP_OFS_MODE1;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl <= 2'h0;
      mask <= 2'h0;
    end
    else if (wr && adr_i == CTP_OFS_CTRL)
    begin
      ctrl <= dat_i[1:0];
    end
    else if (wr && adr_i == CTP_OFS_MASK)
    begin
      mask <= dat_i[1:0];
    end
  end
  a_ack_answer: assert property (req |=> ack_o)
    else $error("bus request not answered");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_unmapped_zero: assert property (ack_o
    && $past(!we_i && adr_i > CTP_OFS_MASK) |-> dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (
    irq_o |-> (mask | $past(mask)) != 2'h0)
    else $error("irq raised while masked");
  a_pulse_oe_cause: assert property (
    $changed(timer_pulse_pin_oe_o) |-> $past(w_m0) || $past(w_m0, 2))
    else $error("pin enable moved without mode write");
  a_shot_oe_cause: assert property (
    $changed(oneshot_pulse_pin_oe_o) |-> $past(w_m1) || $past(w_m1, 2))
    else $error("shot enable moved without mode write");
  // a stop clears the unit pin one edge late and the port one edge later
  a_timer_pin_idle: assert property ($changed(timer_pulse_pin_o)
    |-> ctrl[0] || $past(ctrl[0]) || $past(ctrl[0], 2)
    || $past(ctrl[0], 3))
    else $error("timer pin moved while stopped");
  a_shot_pin_idle: assert property ($changed(oneshot_pulse_pin_o)
    |-> ctrl[1] || $past(ctrl[1]) || $past(ctrl[1], 2)
    || $past(ctrl[1], 3))
    else $error("shot pin moved while stopped");
  c_irq: cover property ($rose(irq_o));
  c_shot: cover property ($rose(oneshot_pulse_pin_o));
  c_tog: cover property ($changed(timer_pulse_pin_o));
endmodule

/* File: tb/ctp_pin_load.sv */
// Purpose: pulled-up load on the shared timer pin
// Assumes: a pull-up holds the line while released
// Notes: logic level only
module ctp_pin_load
(
  input wire logic pin_i,
  input wire logic oe_i,
  output logic level_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // released line settles at the pull-up level
  assign level_o = oe_i ? pin_i : 1'h1;
endmodule

/* File: tb/tb.sv */
// Purpose: bus-driven tests of the timer pair
// Assumes: whole-word accesses with sel 4'hF
// Notes: first underflow may need a full 16-bit count
module tb;
  import ctp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i, rst_i, cyc_i, stb_i, we_i;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, rd;
  logic ack_o, irq_o, timer_pulse_pin_o, timer_pulse_pin_oe_o;
  logic oneshot_pulse_pin_o, oneshot_pulse_pin_oe_o, level;
  int failures = 0;
  int compares = 0;
  int n;
  logic [7:0] ra [7] = '{CTP_OFS_RELOAD0, CTP_OFS_RELOAD1,
    CTP_OFS_COUNT0, CTP_OFS_COUNT1, CTP_OFS_MASK, CTP_OFS_STATUS, 8'h40};
  logic [31:0] re [7] = '{32'hFFFF, 32'hFFFF, 32'hFFFF, 32'hFFFF,
    32'h0, 32'h0, 32'h0};
  logic [7:0] wa [6] = '{CTP_OFS_RELOAD0, CTP_OFS_RELOAD1,
    CTP_OFS_MODE0, CTP_OFS_MODE1, CTP_OFS_MASK, CTP_OFS_CTRL};
  logic [31:0] wd [6] = '{32'h4, 32'h2, 32'h4, 32'h6, 32'h1, 32'h1};
  ctp_top DUT (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cyc_i(cyc_i),
    .stb_i(stb_i),
    .we_i(we_i),
    .adr_i(adr_i),
    .sel_i(sel_i),
    .dat_i(dat_i),
    .dat_o(dat_o),
    .ack_o(ack_o),
    .irq_o(irq_o),
    .timer_pulse_pin_o(timer_pulse_pin_o),
    .timer_pulse_pin_oe_o(timer_pulse_pin_oe_o),
    .oneshot_pulse_pin_o(oneshot_pulse_pin_o),
    .oneshot_pulse_pin_oe_o(oneshot_pulse_pin_oe_o)
  );
  ctp_pin_load load (.pin_i(timer_pulse_pin_o),
    .oe_i(timer_pulse_pin_oe_o), .level_o(level));
  initial
  begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end
  task automatic chk(logic [31:0] got, logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    if (failures == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // request stands until ack is seen at a rising edge; only the watchdog
  // ends a wait that never gets an answer
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do
      @(posedge clk_i);
    while (ack_o !== 1'h1);
    rd = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
    @(posedge clk_i);
  endtask
  // length of a fresh run of level l, in cycles
  task automatic span(ref logic s, input logic l, output int c);
    @(negedge clk_i iff s !== l);
    @(negedge clk_i iff s === l);
    c = 0;
    while (s === l)
    begin
      @(negedge clk_i);
      c++;
    end
    @(posedge clk_i);
  endtask
  initial
  begin
    #4000000;
    failures++;
    summarize();
  end
  initial
  begin
    {cyc_i, stb_i, we_i} = 3'h0;
    adr_i = 8'h0;
    sel_i = 4'hF;
    dat_i = 32'h0;
    rst_i = 1'h1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'h0;
    foreach (ra[i])
    begin
      wb(1'h0, ra[i], 32'h0);
      chk(rd, re[i]);
    end
    foreach (wa[i])
      wb(1'h1, wa[i], wd[i]);
    @(posedge clk_i iff irq_o === 1'h1);
    wb(1'h0, CTP_OFS_STATUS, 32'h0);
    chk(rd, 32'h1);
    chk(timer_pulse_pin_oe_o, 32'h1);
    chk(oneshot_pulse_pin_o, 32'h0);
    span(timer_pulse_pin_o, 1'h1, n);
    chk(n, 32'h5);
    wb(1'h1, CTP_OFS_CTRL, 32'h3);
    chk(oneshot_pulse_pin_oe_o, 32'h1);
    span(oneshot_pulse_pin_o, 1'h1, n);
    chk(n, 32'h2);
    wb(1'h0, CTP_OFS_STATUS, 32'h0);
    chk(rd, 32'h3);
    wb(1'h1, CTP_OFS_MASK, 32'h0);
    chk(irq_o, 32'h0);
    wb(1'h1, CTP_OFS_MODE1, 32'h5);
    span(oneshot_pulse_pin_o, 1'h1, n);
    chk(n, 32'hF);
    wb(1'h0, CTP_OFS_STATUS, 32'h0);
    chk(rd, 32'h3);
    wb(1'h1, CTP_OFS_MODE0, 32'h0);
    chk(timer_pulse_pin_oe_o, 32'h0);
    chk(level, 32'h1);
    wb(1'h1, CTP_OFS_CTRL, 32'h0);
    wb(1'h0, CTP_OFS_STATUS, 32'h0);
    wb(1'h0, CTP_OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule
bind ctp_top ctp_checker u_chk (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .cyc_i(cyc_i),
  .stb_i(stb_i),
  .we_i(we_i),
  .adr_i(adr_i),
  .sel_i(sel_i),
  .dat_i(dat_i),
  .dat_o(dat_o),
  .ack_o(ack_o),
  .irq_o(irq_o),
  .timer_pulse_pin_o(timer_pulse_pin_o),
  .timer_pulse_pin_oe_o(timer_pulse_pin_oe_o),
  .oneshot_pulse_pin_o(oneshot_pulse_pin_o),
  .oneshot_pulse_pin_oe_o(oneshot_pulse_pin_oe_o)
);
